// ===== shared/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// ****************************************
// register byte addresses, one per word
// ****************************************
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_CNT_LO     8'h08
`define OFS_CNT_HI     8'h0c
`define OFS_CMPA_LO    8'h10
`define OFS_CMPA_HI    8'h14
`define OFS_FLAGS      8'h18
// ****************************************
// field positions
// ****************************************
`define CTRL0_PAUSE    7
`define CTRL0_RUN      3
`define CTRL1_INIT     3
`define CTRL1_INV      2
`define CTRL1_SWAP     1
`define CTRL1_CLRSEL   0
`define FLAG_A         0
`define FLAG_P         1
`define CTRL_RESET     8'h00
`define P_STEP_SHIFT   7
`define CNT_MAX        10'h3ff
`endif

// ===== shared/timer_pkg.sv
package timer_pkg;
  typedef enum logic [1:0] {MODE_CMP = 2'b00, MODE_UNDEF = 2'b01, MODE_PWM = 2'b10, MODE_TMR = 2'b11} op_mode_t;
  typedef struct packed {
    logic     counter_pause;
    logic [2:0] clock_source_sel;
    logic     counter_run_switch;
    logic [2:0] compare_value_p;
  } ctrl0_t;
  typedef struct packed {
    op_mode_t   op_mode;
    logic [1:0] output_action;
    logic       output_initial_level;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } ctrl1_t;
endpackage

// ===== hdl/compact_timer_pwm_core.sv
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "timer_defines.svh"
// Operation
// - compare mode A match: hold, low, high, toggle
// - pwm action: inactive, active, waveform, undefined
// - run rise restores initial output level
// - initial bit sets compare-mode start level
// - initial bit sets pwm active level
// - invert bit inverts final output
// - swap bit exchanges period and duty roles
// - clear source: A match or P/overflow
// - counter read as low and high bytes
// - compare A ten bits, two bytes
// - mode field: 00 cmp, 10 pwm, 11 timer
// - clear-on-P sets both match flags
// - clear-on-A never sets P flag outside pwm mode
// - A zero overflows at 3ff, no flag
// - only A match and run rise change compare output
// - timer mode counts like compare, no output
// - pwm sets both flags on matches
// - swap 0: period 128*P, duty A
// - duty at least period gives full active
// - swap 1: period A, duty 128*P
// - pwm counting continues while output forced
// - run rise clears counter, fall holds
// - P compares counter bits 9 to 7
// - clock source select, eight codes but seven sources (100 and 101 both pick the sub divider)
// - pause holds counter, resume continues
module compact_timer_pwm_core
  import timer_pkg::*;
#(
  parameter int H_DIV   = 16,
  parameter int H2_DIV  = 64,
  parameter int SUB_DIV = 312
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        sine_generator_edge_signal_i,
  output logic             timer_output_o,
  output logic             match_a_flag_o,
  output logic             match_p_flag_o
);
  // ****************************************
  // register bus
  // ****************************************
  ctrl0_t     ctrl0_r;
  ctrl1_t     ctrl1_r;
  logic [9:0] cmpa_r;
  logic [7:0] wbuf_r;
  logic [7:0] rbuf_r;
  logic [9:0] cnt_r;
  logic       flag_a_r;
  logic       flag_p_r;
  logic       out_r;
  logic       run_d_r;
  logic       edge_d_r;
  logic       wr;
  logic       rd;
  logic       req;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr  = req & we_i & sel_i[0];
  assign rd  = req & ~we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // split-byte writes: low byte buffered until high byte written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl0_r <= ctrl0_t'(`CTRL_RESET);
      ctrl1_r <= ctrl1_t'(`CTRL_RESET);
      cmpa_r  <= 10'h000;
      wbuf_r  <= 8'h00;
    end
    else if (wr)
    begin
      unique case (adr_i)
        `OFS_CTRL0:   ctrl0_r <= ctrl0_t'(dat_i[7:0]);
        `OFS_CTRL1:   ctrl1_r <= ctrl1_t'(dat_i[7:0]);
        `OFS_CMPA_LO: wbuf_r  <= dat_i[7:0];
        `OFS_CMPA_HI: cmpa_r  <= {dat_i[1:0], wbuf_r};
        default:      ;
      endcase
    end
  end

  // high-byte read latches the low byte so a pair is coherent
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rbuf_r <= 8'h00;
    else if (rd && adr_i == `OFS_CNT_HI)
      rbuf_r <= cnt_r[7:0];
    else if (rd && adr_i == `OFS_CMPA_HI)
      rbuf_r <= cmpa_r[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (adr_i)
        `OFS_CTRL0:   dat_o <= {24'h000000, ctrl0_r};
        `OFS_CTRL1:   dat_o <= {24'h000000, ctrl1_r};
        `OFS_CNT_LO:  dat_o <= {24'h000000, rbuf_r};
        `OFS_CNT_HI:  dat_o <= {30'h00000000, cnt_r[9:8]};
        `OFS_CMPA_LO: dat_o <= {24'h000000, rbuf_r};
        `OFS_CMPA_HI: dat_o <= {30'h00000000, cmpa_r[9:8]};
        `OFS_FLAGS:   dat_o <= {30'h00000000, flag_p_r, flag_a_r};
        default:      dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // clock source ticks
  // ****************************************
  logic [1:0]  div4_r;
  logic [5:0]  divh_r;
  logic [8:0]  divs_r;
  logic        tick;
  logic        edge_rise;
  logic        edge_fall;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div4_r   <= 2'h0;
      divh_r   <= 6'h00;
      divs_r   <= 9'h000;
      edge_d_r <= 1'b0;
    end
    else
    begin
      div4_r   <= div4_r + 2'h1;
      divh_r   <= (divh_r == 6'(H2_DIV - 1)) ? 6'h00 : divh_r + 6'h01;
      divs_r   <= (divs_r == 9'(SUB_DIV - 1)) ? 9'h000 : divs_r + 9'h001;
      edge_d_r <= sine_generator_edge_signal_i;
    end
  end

  assign edge_rise = sine_generator_edge_signal_i & ~edge_d_r;
  assign edge_fall = ~sine_generator_edge_signal_i & edge_d_r;

  always_comb
  begin
    unique case (ctrl0_r.clock_source_sel)
      3'b000:  tick = (div4_r == 2'h3);
      3'b001:  tick = 1'b1;
      3'b010:  tick = (divh_r[3:0] == 4'(H_DIV - 1));
      3'b011:  tick = (divh_r == 6'(H2_DIV - 1));
      3'b110:  tick = edge_rise;
      3'b111:  tick = edge_fall;
      default: tick = (divs_r == 9'(SUB_DIV - 1));
    endcase
  end

  // ****************************************
  // counter and comparators
  // ****************************************
  logic       run_rise;
  logic       step;
  logic       pwm;
  logic       match_a;
  logic       match_p;
  logic       clr_a;
  logic       clr;
  logic       set_a;
  logic       set_p;
  logic [10:0] period;
  logic [10:0] duty;
  logic [10:0] p_len;

  assign pwm      = (ctrl1_r.op_mode == MODE_PWM);
  assign run_rise = ctrl0_r.counter_run_switch & ~run_d_r;
  assign step     = ctrl0_r.counter_run_switch & ~ctrl0_r.counter_pause & tick;
  // a zero P code means 1024, i.e. the count wraps at 3ff
  assign p_len    = (ctrl0_r.compare_value_p == 3'h0) ? 11'h400
                  : {1'b0, ctrl0_r.compare_value_p, 7'h00};
  assign match_p  = step && (cnt_r + 10'h001) == p_len[9:0] && ctrl0_r.compare_value_p != 3'h0;
  assign match_a  = step && (cnt_r + 10'h001) == cmpa_r && cmpa_r != 10'h000;
  assign clr_a    = pwm ? ctrl1_r.period_duty_swap : ctrl1_r.clear_source_select;
  assign clr      = step && (clr_a ? (match_a || cnt_r == `CNT_MAX)
                                   : (match_p || cnt_r == `CNT_MAX));
  assign set_a    = match_a;
  assign set_p    = match_p && (pwm || !ctrl1_r.clear_source_select);
  assign period   = ctrl1_r.period_duty_swap ? ((cmpa_r == 10'h000) ? 11'h400 : {1'b0, cmpa_r}) : p_len;
  assign duty     = ctrl1_r.period_duty_swap ? p_len : {1'b0, cmpa_r};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r   <= 10'h000;
      run_d_r <= 1'b0;
    end
    else
    begin
      run_d_r <= ctrl0_r.counter_run_switch;
      if (run_rise)
        cnt_r <= 10'h000;
      else if (clr)
        cnt_r <= 10'h000;
      else if (step)
        cnt_r <= cnt_r + 10'h001;
    end
  end

  // flags stay set until software writes 1; a new set beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end
    else
    begin
      flag_a_r <= set_a | (flag_a_r & ~(wr && adr_i == `OFS_FLAGS && dat_i[`FLAG_A]));
      flag_p_r <= set_p | (flag_p_r & ~(wr && adr_i == `OFS_FLAGS && dat_i[`FLAG_P]));
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  logic pwm_act;
  logic lvl;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_r <= 1'b0;
    else if (run_rise)
      out_r <= ctrl1_r.output_initial_level;
    else if (ctrl1_r.op_mode == MODE_CMP && set_a)
    begin
      unique case (ctrl1_r.output_action)
        2'b00: out_r <= out_r;
        2'b01: out_r <= 1'b0;
        2'b10: out_r <= 1'b1;
        2'b11: out_r <= ~out_r;
      endcase
    end
  end

  // duty >= period keeps active whole period
  assign pwm_act = ({1'b0, cnt_r} < duty) || (duty >= period);

  always_comb
  begin
    unique case (ctrl1_r.output_action)
      2'b00:   lvl = ~ctrl1_r.output_initial_level;
      2'b01:   lvl = ctrl1_r.output_initial_level;
      2'b10:   lvl = pwm_act ? ctrl1_r.output_initial_level : ~ctrl1_r.output_initial_level;
      default: lvl = 1'b0;
    endcase
  end

  // timer mode output undefined; held low here
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_output_o <= 1'b0;
    else if (pwm)
      timer_output_o <= lvl ^ ctrl1_r.output_invert;
    else if (ctrl1_r.op_mode == MODE_CMP)
      timer_output_o <= out_r ^ ctrl1_r.output_invert;
    else
      timer_output_o <= 1'b0;
  end

  assign match_a_flag_o = flag_a_r;
  assign match_p_flag_o = flag_p_r;
endmodule // compact_timer_pwm_core

// ===== test/timer_sva.sv
`timescale 1ns/10ps
// ****
// bus and flag checks
// ****
module timer_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        match_a_flag_o,
  input wire logic        match_p_flag_o
);
  logic rd;
  logic clr;
  assign rd  = cyc_i && stb_i && !we_i && !ack_o;
  assign clr = cyc_i && stb_i && we_i && adr_i == 8'h18;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_due: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_cnt_hi_pad: assert property (rd && adr_i == 8'h0c |=> dat_o[31:2] == 30'h0)
    else $error("counter high byte pad");
  a_cmpa_hi_pad: assert property (rd && adr_i == 8'h14 |=> dat_o[31:2] == 30'h0)
    else $error("compare high byte pad");
  a_dat_hold: assert property (!rd |=> $stable(dat_o))
    else $error("read data moved");
  a_flag_a_hold: assert property (match_a_flag_o && !clr |=> match_a_flag_o)
    else $error("a flag lost");
  a_flag_p_hold: assert property (match_p_flag_o && !clr |=> match_p_flag_o)
    else $error("p flag lost");
endmodule // timer_sva
bind compact_timer_pwm_core timer_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .match_a_flag_o(match_a_flag_o),
  .match_p_flag_o(match_p_flag_o));

// ===== test/testbench.sv
`timescale 1ns/10ps
// ****
// stimulus and checks
// ****
module testbench;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc   = 1'h0;
  logic        stb   = 1'h0;
  logic        we    = 1'h0;
  logic        edg   = 1'h0;
  logic [7:0]  adr   = 8'h0;
  logic [31:0] dw    = 32'h0;
  logic [31:0] dr;
  logic [31:0] q;
  logic [9:0]  c;
  logic        ack;
  logic        tout;
  logic        fa;
  logic        fp;
  int          bad_count = 0;
  int          total_checks = 0;
  always #50 clk_i = ~clk_i;
  compact_timer_pwm_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dw), .dat_o(dr), .ack_o(ack), .sine_generator_edge_signal_i(edg),
    .timer_output_o(tout), .match_a_flag_o(fa), .match_p_flag_o(fp));
  task automatic summarize;
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("[ERR] %0t wait timed out", $time);
    summarize();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= a;
    dw  <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = dr;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20)
      hang();
  endtask
  // flags cleared after run so stale matches never leak between scenarios
  task automatic start(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h04, {24'h0, c1});
    bus(1'h1, 8'h10, {24'h0, a[7:0]});
    bus(1'h1, 8'h14, {30'h0, a[9:8]});
    bus(1'h1, 8'h00, {24'h0, c0});
    bus(1'h1, 8'h18, 32'h3);
  endtask
  task automatic rcnt;
    bus(1'h0, 8'h0c, 32'h0);
    c[9:8] = q[1:0];
    bus(1'h0, 8'h08, 32'h0);
    c[7:0] = q[7:0];
  endtask
  task automatic waitf(input logic p);
    int n;
    n = 0;
    while ((p ? fp : fa) !== 1'h1 && n < 1200)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1200)
      hang();
  endtask
  task automatic pulse(input int k);
    repeat (k)
    begin
      @(posedge clk_i);
      edg <= 1'h1;
      @(posedge clk_i);
      edg <= 1'h0;
    end
    @(posedge clk_i);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'h0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    bus(1'h1, 8'h10, 32'h5a);
    bus(1'h1, 8'h14, 32'hff);
    bus(1'h1, 8'h08, 32'hff);
    bus(1'h0, 8'h14, 32'h0);
    chk(q, 32'h3);
    bus(1'h0, 8'h10, 32'h0);
    chk(q, 32'h5a);
    rcnt();
    chk(c, 10'h0);
  endtask
  task automatic t_cmp;
    logic e;
    for (int i = 0; i < 16; i++)
    begin
      start({2'h0, i[1:0], i[2], i[3], 2'h1}, 10'h14, 8'h18);
      chk(tout, i[2] ^ i[3]);
      waitf(1'h0);
      bus(1'h0, 8'h18, 32'h0);
      chk(q[1], 1'h0);
      e = i[1:0] == 2'h0 ? i[2] : i[1:0] == 2'h1 ? 1'h0 : i[1:0] == 2'h2 ? 1'h1 : !i[2];
      chk(tout, e ^ i[3]);
    end
  endtask
  task automatic t_clrp;
    for (int j = 0; j < 2; j++)
    begin
      start(j ? 8'he0 : 8'h20, j ? 10'h40 : 10'h200, 8'h19);
      waitf(1'h1);
      rcnt();
      chk(c[9:4], 6'h0);
      chk(fa, j);
      chk(tout, 1'h0);
    end
  endtask
  task automatic t_pwm(input logic [7:0] c1, input logic [9:0] a, input int e);
    int n;
    n = 0;
    start(c1, a, 8'h19);
    repeat (256)
    begin
      @(posedge clk_i);
      n += (tout === 1'h1);
    end
    chk(n, e);
    chk(fp, 1'h1);
  endtask
  task automatic t_edge;
    start(8'h01, 10'h0, 8'h68);
    pulse(10);
    rcnt();
    chk(c, 10'h00a);
    bus(1'h1, 8'h00, 32'h78);
    pulse(5);
    rcnt();
    chk(c, 10'h00f);
    bus(1'h1, 8'h00, 32'hf8);
    pulse(5);
    bus(1'h1, 8'h00, 32'h78);
    pulse(1);
    rcnt();
    chk(c, 10'h010);
    bus(1'h1, 8'h00, 32'h70);
    pulse(2);
    rcnt();
    chk(c, 10'h010);
    bus(1'h1, 8'h00, 32'h78);
    rcnt();
    chk(c, 10'h0);
    bus(1'h1, 8'h00, 32'h18);
    repeat (1100) @(posedge clk_i);
    chk(fa, 1'h0);
  endtask
  // latch points of two rcnt calls lie k+6 edges apart, a whole number of divider periods
  task automatic t_div(input logic [7:0] c0, input int k, input logic [9:0] e);
    logic [9:0] c_first;
    start(8'h01, 10'h0, c0);
    rcnt();
    c_first = c;
    repeat (k) @(posedge clk_i);
    rcnt();
    chk(10'(c - c_first), e);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs();
    t_cmp();
    t_clrp();
    t_pwm(8'ha8, 10'h20, 64);
    t_pwm(8'ha0, 10'h20, 192);
    t_pwm(8'hac, 10'h20, 192);
    t_pwm(8'ha8, 10'h80, 256);
    t_pwm(8'haa, 10'h100, 128);
    t_pwm(8'h88, 10'h20, 0);
    t_pwm(8'h98, 10'h20, 256);
    t_edge();
    t_div(8'h08, 394, 10'h064);
    t_div(8'h28, 394, 10'h019);
    t_div(8'h38, 634, 10'h00a);
    t_div(8'h48, 618, 10'h002);
    summarize();
  end
endmodule // testbench
